// ==== logic/agisr_cfg.svh ====
// Purpose: Offsets, field positions, reset values and counts of the
//          gain, input and status register bank.
// Assumes: Register index times four is the byte address.
// Notes:   Definitions only.
`ifndef AGISR_CFG_SVH
`define AGISR_CFG_SVH

// ==========================================================
// Register indices
`define AGISR_IDX_CLKDIV 5'h05
`define AGISR_IDX_AMP 5'h06
`define AGISR_IDX_GAIN_R 5'h07
`define AGISR_IDX_GAIN_L 5'h08
`define AGISR_IDX_INCTL 5'h09
`define AGISR_IDX_POL 5'h0C
`define AGISR_IDX_STAT 5'h0D
`define AGISR_IDX_MASK 5'h0E
`define AGISR_IDX_MODE_HI 5'h0F
`define AGISR_IDX_MODE_LO 5'h10
`define AGISR_IDX_HOLD 5'h11

// ==========================================================
// Field positions
`define AGISR_DIV_MSB 6
`define AGISR_DIV_LSB 4
`define AGISR_AMP_BIT 6
`define AGISR_SOFT_BIT 4
`define AGISR_ZERO_BIT 3
`define AGISR_FREEZE_BIT 0
`define AGISR_MUTE_BIT 1
`define AGISR_STAT_VALID 8'h0B

// ==========================================================
// Reset values
`define AGISR_RST_DIV 3'h0
`define AGISR_RST_AMP 1'b1
`define AGISR_RST_GAIN 6'h00
`define AGISR_RST_SEL 3'h1
`define AGISR_RST_BYTE 8'h00

// ==========================================================
// Counts
`define AGISR_TMO_LAST 10'h1FF
`define AGISR_MUTE_LEVEL 8'h80

`endif

// ==== logic/agisr_ch_if.sv ====
// Purpose: Carries one channel's target and pacing to its gain engine.
// Assumes: All signals belong to the one device clock.
// Notes:   None.
`timescale 1ns/1ps
interface agisr_ch_if;
  import agisr_pkg::*;
  agisr_level_t target;
  agisr_xmode_e xmode;
  logic tick;
  logic zc;
  agisr_level_t level;
  modport engine (input target, input xmode, input tick, input zc,
                  output level);
  modport ctrl (output target, output xmode, output tick, output zc,
                input level);
endinterface

// ==== logic/agisr_gain_ramp.sv ====
// Purpose: Moves one channel's applied level toward its target.
// Assumes: tick pulses once per sample period; zc pulses on a crossing.
// Notes:   The timeout fires 512 sample periods after the last change.
`timescale 1ns/1ps
`include "agisr_cfg.svh"
module agisr_gain_ramp
  import agisr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  agisr_ch_if.engine ch
);
  agisr_level_t level_q, level_d, stepped;
  logic [9:0] tmo_q, tmo_d;
  logic differs, rising, fire;

  // ==========================================================
  // Step selection
  assign differs = (ch.target != level_q);
  assign rising = (ch.target > level_q);
  assign stepped = rising ? agisr_level_t'(level_q + 8'sd1)
                          : agisr_level_t'(level_q - 8'sd1);
  assign fire = ch.zc || (ch.tick && (tmo_q == `AGISR_TMO_LAST));
  assign ch.level = level_q;

  always_comb begin
    level_d = level_q;
    unique case (ch.xmode)
      XM_IMMED: level_d = ch.target;
      XM_SOFT: if (differs && ch.tick) level_d = stepped;
      XM_ZERO: if (differs && fire) level_d = ch.target;
      XM_BOTH: if (differs && fire) level_d = stepped;
    endcase
  end

  // The wait restarts after every change so each step gets its own timeout.
  always_comb begin
    tmo_d = tmo_q;
    if (!differs || (level_d != level_q)) begin
      tmo_d = 10'h000;
    end else if (ch.tick) begin
      tmo_d = 10'(tmo_q + 10'h001);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 8'h00;
      tmo_q <= 10'h000;
    end else if (clk_en) begin
      level_q <= level_d;
      tmo_q <= tmo_d;
    end
  end

  // ==========================================================
  // Checks
  chk_soft_one_step: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && ch.xmode == XM_SOFT && ch.tick && differs |=>
    (level_q == agisr_level_t'($past(level_q) + 8'sd1)) ||
    (level_q == agisr_level_t'($past(level_q) - 8'sd1)))
    else $error("soft ramp did not move by one eighth dB");
  chk_zero_waits: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && ch.xmode == XM_ZERO && !fire |=> $stable(level_q))
    else $error("zero cross level changed without a crossing");
  chk_tmo_bound: assert property (@(posedge clock) disable iff (!reset_n)
    tmo_q <= `AGISR_TMO_LAST)
    else $error("zero cross timeout counter overran");
  chk_immed_apply: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && ch.xmode == XM_IMMED |=> level_q == $past(ch.target))
    else $error("immediate mode did not apply target");
  cov_timeout_fire: cover property (@(posedge clock) disable iff (!reset_n)
    differs && ch.tick && tmo_q == `AGISR_TMO_LAST && !ch.zc);
  cov_ramp_done: cover property (@(posedge clock) disable iff (!reset_n)
    ch.xmode == XM_SOFT && differs ##1 !differs);
endmodule // agisr_gain_ramp

// ==== logic/agisr_pkg.sv ====
// Purpose: Types shared by the register bank and the gain engine.
// Assumes: Levels are signed eighths of a decibel.
// Notes:   None.
package agisr_pkg;
  typedef logic signed [7:0] agisr_level_t;
  typedef enum logic [1:0] {
    XM_IMMED = 2'b00,
    XM_ZERO = 2'b01,
    XM_SOFT = 2'b10,
    XM_BOTH = 2'b11
  } agisr_xmode_e;
  typedef enum logic [1:0] {
    SM_RISE = 2'b00,
    SM_FALL = 2'b01,
    SM_LEVEL = 2'b10,
    SM_RSVD = 2'b11
  } agisr_smode_e;
endpackage

// ==== logic/agisr_top.sv ====
// Purpose: Control and status registers of a stereo audio converter.
// Assumes: Avalon-MM slave, one wait state, data in byte lane 0.
// Notes:   Status sources and crossing pulses come from the local clock.
`timescale 1ns/1ps
`include "agisr_cfg.svh"
module agisr_top
  import agisr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mclk_pin,
  input wire logic lrck_pin,
  input wire logic [1:0] zero_cross,
  input wire logic clock_fault,
  input wire logic over_range,
  input wire logic under_range,
  output logic mclk_div_tick,
  output logic amp_out_a_oe,
  output logic amp_out_b_oe,
  output logic [2:0] mux_sel,
  output logic mic_boost_en,
  output logic irq_out,
  output logic irq_oe,
  output logic [7:0] left_level,
  output logic [7:0] right_level
);
  // ==========================================================
  // Register state
  logic wait_q;
  logic [31:0] rdata_q;
  logic [2:0] clkdiv_q;
  logic amp_en_q;
  logic [5:0] gain_q [2];
  logic [5:0] gain_app_q [2];
  logic soft_q, zero_q;
  logic [2:0] sel_q;
  logic pol_q;
  logic [7:0] mask_q, mode_hi_q, mode_lo_q, status_q, cond_prev_q;
  logic freeze_q, mute_q, mute_app_q;
  agisr_level_t level_w [2];

  // ==========================================================
  // Bus decode
  logic [4:0] idx;
  logic wr_go, rd_go;
  logic hit_div, hit_amp, hit_gr, hit_gl, hit_in, hit_pol;
  logic hit_stat, hit_mask, hit_mhi, hit_mlo, hit_hold;
  logic [7:0] wbyte, rd_mux, clr_bits;
  assign idx = avs_address[6:2];
  assign wr_go = avs_write && !wait_q && avs_byteenable[0];
  assign rd_go = avs_read && !wait_q;
  assign wbyte = avs_writedata[7:0];
  assign hit_div = (idx == `AGISR_IDX_CLKDIV);
  assign hit_amp = (idx == `AGISR_IDX_AMP);
  assign hit_gr = (idx == `AGISR_IDX_GAIN_R);
  assign hit_gl = (idx == `AGISR_IDX_GAIN_L);
  assign hit_in = (idx == `AGISR_IDX_INCTL);
  assign hit_pol = (idx == `AGISR_IDX_POL);
  assign hit_stat = (idx == `AGISR_IDX_STAT);
  assign hit_mask = (idx == `AGISR_IDX_MASK);
  assign hit_mhi = (idx == `AGISR_IDX_MODE_HI);
  assign hit_mlo = (idx == `AGISR_IDX_MODE_LO);
  assign hit_hold = (idx == `AGISR_IDX_HOLD);

  // Unmapped offsets read as zero and ignore writes.
  assign rd_mux =
    hit_div ? {1'b0, clkdiv_q, 4'h0} :
    hit_amp ? {1'b0, amp_en_q, 6'h00} :
    hit_gr ? {2'b00, gain_q[1]} :
    hit_gl ? {2'b00, gain_q[0]} :
    hit_in ? {3'b000, soft_q, zero_q, sel_q} :
    hit_pol ? {7'h00, pol_q} :
    hit_stat ? (status_q & mask_q) :
    hit_mask ? mask_q :
    hit_mhi ? mode_hi_q :
    hit_mlo ? mode_lo_q :
    hit_hold ? {6'h00, mute_q, freeze_q} :
    8'h00;

  // One wait state: the request is seen, data captured, then released.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else if (clk_en) begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= {24'h000000, rd_mux};
      end
    end
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ==========================================================
  // Control registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clkdiv_q <= `AGISR_RST_DIV;
      amp_en_q <= `AGISR_RST_AMP;
      soft_q <= 1'b1;
      zero_q <= 1'b1;
      sel_q <= `AGISR_RST_SEL;
      pol_q <= 1'b0;
    end else if (clk_en && wr_go) begin
      if (hit_div) clkdiv_q <= wbyte[`AGISR_DIV_MSB:`AGISR_DIV_LSB];
      if (hit_amp) amp_en_q <= wbyte[`AGISR_AMP_BIT];
      if (hit_in) soft_q <= wbyte[`AGISR_SOFT_BIT];
      if (hit_in) zero_q <= wbyte[`AGISR_ZERO_BIT];
      if (hit_in) sel_q <= wbyte[2:0];
      if (hit_pol) pol_q <= wbyte[0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= `AGISR_RST_BYTE;
      mode_hi_q <= `AGISR_RST_BYTE;
      mode_lo_q <= `AGISR_RST_BYTE;
      freeze_q <= 1'b0;
      mute_q <= 1'b0;
    end else if (clk_en && wr_go) begin
      if (hit_mask) mask_q <= wbyte & `AGISR_STAT_VALID;
      if (hit_mhi) mode_hi_q <= wbyte & `AGISR_STAT_VALID;
      if (hit_mlo) mode_lo_q <= wbyte & `AGISR_STAT_VALID;
      if (hit_hold) freeze_q <= wbyte[`AGISR_FREEZE_BIT];
      if (hit_hold) mute_q <= wbyte[`AGISR_MUTE_BIT];
    end
  end

  // Gain codes outside the allowed span are stored as written.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gain_q[0] <= `AGISR_RST_GAIN;
      gain_q[1] <= `AGISR_RST_GAIN;
    end else if (clk_en && wr_go) begin
      if (hit_gl) gain_q[0] <= wbyte[5:0];
      if (hit_gr) gain_q[1] <= wbyte[5:0];
    end
  end

  // Pending values pass to the engines only while freeze is clear.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gain_app_q[0] <= `AGISR_RST_GAIN;
      gain_app_q[1] <= `AGISR_RST_GAIN;
      mute_app_q <= 1'b0;
    end else if (clk_en && !freeze_q) begin
      gain_app_q[0] <= gain_q[0];
      gain_app_q[1] <= gain_q[1];
      mute_app_q <= mute_q;
    end
  end

  // ==========================================================
  // Pin synchronisers and master clock divider
  logic [2:0] mclk_sync_q, lrck_sync_q;
  logic [3:0] acc_q, acc_sum, div_lim;
  logic mclk_rise, lr_tick, div_fire, div_tick_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mclk_sync_q <= 3'h0;
      lrck_sync_q <= 3'h0;
    end else if (clk_en) begin
      mclk_sync_q <= {mclk_sync_q[1:0], mclk_pin};
      lrck_sync_q <= {lrck_sync_q[1:0], lrck_pin};
    end
  end
  assign mclk_rise = mclk_sync_q[1] && !mclk_sync_q[2];
  assign lr_tick = lrck_sync_q[1] && !lrck_sync_q[2];

  // The accumulator counts half input periods, which gives the 1.5 ratio.
  assign div_lim = (clkdiv_q == 3'h0) ? 4'h2 :
                   (clkdiv_q == 3'h1) ? 4'h3 :
                   (clkdiv_q == 3'h2) ? 4'h4 :
                   (clkdiv_q == 3'h3) ? 4'h6 :
                   (clkdiv_q == 3'h4) ? 4'h8 : 4'h0;
  assign acc_sum = 4'(acc_q + 4'h2);
  assign div_fire = mclk_rise && (div_lim != 4'h0) && (acc_sum >= div_lim);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= 4'h0;
      div_tick_q <= 1'b0;
    end else if (clk_en) begin
      div_tick_q <= div_fire;
      if (div_lim == 4'h0) begin
        acc_q <= 4'h0;
      end else if (mclk_rise) begin
        acc_q <= div_fire ? 4'(acc_sum - div_lim) : acc_sum;
      end
    end
  end
  assign mclk_div_tick = div_tick_q;

  // ==========================================================
  // Gain engines, one per channel; index 0 is left, 1 is right
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : gen_ch
      agisr_ch_if ch_bus ();
      // Muting rides the same transition path as a gain change.
      assign ch_bus.target = mute_app_q ?
        agisr_level_t'(`AGISR_MUTE_LEVEL) :
        agisr_level_t'({gain_app_q[c], 2'b00});
      assign ch_bus.xmode = agisr_xmode_e'({soft_q, zero_q});
      assign ch_bus.tick = lr_tick;
      assign ch_bus.zc = zero_cross[c];
      assign level_w[c] = ch_bus.level;
      agisr_gain_ramp u_ramp (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .ch(ch_bus.engine)
      );
    end
  endgenerate
  assign left_level = level_w[0];
  assign right_level = level_w[1];

  // ==========================================================
  // Status events
  logic [7:0] cond_vec, ev_vec, ev_masked;
  assign cond_vec = {4'h0, clock_fault, 1'b0, over_range, under_range};
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : gen_ev
      agisr_smode_e md;
      assign md = agisr_smode_e'({mode_hi_q[b], mode_lo_q[b]});
      assign ev_vec[b] =
        (md == SM_RISE) ? (cond_vec[b] && !cond_prev_q[b]) :
        (md == SM_FALL) ? (!cond_vec[b] && cond_prev_q[b]) :
        (md == SM_LEVEL) ? cond_vec[b] : 1'b0;
    end
  endgenerate
  assign ev_masked = ev_vec & mask_q & `AGISR_STAT_VALID;
  // Only bits already handed to software are cleared, and a new event wins.
  assign clr_bits = (rd_go && hit_stat) ? rdata_q[7:0] : 8'h00;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= `AGISR_RST_BYTE;
      cond_prev_q <= `AGISR_RST_BYTE;
    end else if (clk_en) begin
      status_q <= (status_q & ~clr_bits) | ev_masked;
      cond_prev_q <= cond_vec;
    end
  end

  // ==========================================================
  // Pins driven from configuration
  logic irq_any;
  assign irq_any = |(status_q & mask_q);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      amp_out_a_oe <= 1'b0;
      amp_out_b_oe <= 1'b0;
      mux_sel <= `AGISR_RST_SEL;
      mic_boost_en <= 1'b0;
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
    end else if (clk_en) begin
      amp_out_a_oe <= amp_en_q;
      amp_out_b_oe <= amp_en_q;
      mux_sel <= sel_q;
      mic_boost_en <= (sel_q == 3'h0);
      irq_out <= pol_q && irq_any;
      irq_oe <= pol_q || irq_any;
    end
  end

  // ==========================================================
  // Checks
  chk_div_by_one: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && clkdiv_q == 3'h0 && mclk_rise |=> div_tick_q)
    else $error("divide by one missed a tick");
  // The sampled reset keeps the release edge out, as the pins still hold reset.
  chk_amp_pins: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n && clk_en && $stable(amp_en_q) |=>
    amp_out_a_oe == $past(amp_en_q) && amp_out_b_oe == amp_out_a_oe)
    else $error("amplifier pin enables disagree with control bit");
  chk_mic_boost: assert property (@(posedge clock) disable iff (!reset_n)
    mic_boost_en == (mux_sel == 3'h0))
    else $error("boost not tied to microphone select");
  chk_irq_polarity: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en ##1 clk_en |=> (pol_q != $past(pol_q, 2)) ||
    (pol_q ? irq_oe : !irq_out))
    else $error("interrupt pin drive wrong for polarity");
  chk_read_masked: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && avs_read && wait_q && hit_stat |=>
    (avs_readdata[7:0] & ~$past(mask_q)) == 8'h00)
    else $error("masked status bit read as one");
  chk_read_clears: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && rd_go && hit_stat && ev_masked == 8'h00 |=>
    (status_q & $past(rdata_q[7:0])) == 8'h00)
    else $error("status read did not clear reported bits");
  chk_set_wins: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en |=> (status_q & $past(ev_masked)) == $past(ev_masked))
    else $error("status event lost");
  chk_mask_blocks: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en |=> (status_q & ~$past(status_q) & ~$past(ev_masked)) == 8'h00)
    else $error("status bit set without unmasked event");
  chk_freeze_hold: assert property (@(posedge clock) disable iff (!reset_n)
    freeze_q |=> $stable(gain_app_q[0]) && $stable(mute_app_q))
    else $error("frozen gain or mute changed");
  chk_irq_follows: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pol_q ##1 clk_en && pol_q |-> irq_out == $past(irq_any))
    else $error("interrupt pin not following status");
  cov_status_read: cover property (@(posedge clock) disable iff (!reset_n)
    rd_go && hit_stat && rdata_q[3]);
  cov_freeze_release: cover property (@(posedge clock) disable iff (!reset_n)
    freeze_q ##1 !freeze_q);
  cov_div_half: cover property (@(posedge clock) disable iff (!reset_n)
    clkdiv_q == 3'h1 && div_tick_q);
endmodule // agisr_top

// ==== sim/adc_gain_input_status_regs_tb.sv ====
// Purpose: Self-checking bench of the register bank.
// Assumes: Fast sample clock so that pacing stays short.
// Notes:   Reads are judged by a monitor against queued bytes.
`timescale 1ns/1ps
module adc_gain_input_status_regs_tb;
  import agisr_pkg::*;
  logic clock, reset_n, mclk_pin, lrck_pin, clk_en;
  logic [1:0] zero_cross;
  logic clock_fault, over_range, under_range;
  logic [6:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic mclk_div_tick, amp_out_a_oe, amp_out_b_oe, mic_boost_en;
  logic irq_out, irq_oe;
  logic [2:0] mux_sel;
  logic [7:0] left_level, right_level;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 8;
  int g;
  logic [7:0] lvl;
  agisr_top u_dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mclk_pin(mclk_pin),
    .lrck_pin(lrck_pin), .zero_cross(zero_cross),
    .clock_fault(clock_fault), .over_range(over_range),
    .under_range(under_range), .mclk_div_tick(mclk_div_tick),
    .amp_out_a_oe(amp_out_a_oe), .amp_out_b_oe(amp_out_b_oe),
    .mux_sel(mux_sel), .mic_boost_en(mic_boost_en), .irq_out(irq_out),
    .irq_oe(irq_oe), .left_level(left_level),
    .right_level(right_level));
  agisr_host u_host (.clock(clock), .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));
  // ==========================================================
  // Clock, pins and checks
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {reset_n, mclk_pin, lrck_pin, zero_cross} = 5'h00;
    {clock_fault, over_range, under_range} = 3'h0;
    clk_en = 1'b1;
  end
  always @(posedge clock) mclk_pin <= ~mclk_pin;
  always begin
    repeat (4) @(posedge clock);
    lrck_pin <= ~lrck_pin;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  always @(posedge clock) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (u_host.exp_q.size() == 0) chk(8'hEE, 8'h00);
      else chk(avs_readdata[7:0], u_host.exp_q.pop_front());
    end
  end
  task automatic print_verdict;
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    print_verdict();
  end
  task automatic pulse_cond(input int which);
    @(posedge clock);
    {clock_fault, over_range, under_range} <= 3'(1 << which);
    repeat (2) @(posedge clock);
    {clock_fault, over_range, under_range} <= 3'h0;
    repeat (3) @(posedge clock);
  endtask
  // Settling first keeps the carry left over from the old ratio out.
  task automatic count_ticks(input int span, input int want);
    int n;
    n = 0;
    repeat (20) @(posedge clock);
    repeat (span) begin
      @(posedge clock);
      if (mclk_div_tick === 1'b1) n++;
    end
    chk(8'(n), 8'(want));
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    u_host.rd(7'h14, 8'h00);
    u_host.rd(7'h18, 8'h40);
    u_host.rd(7'h1C, 8'h00);
    u_host.rd(7'h20, 8'h00);
    u_host.rd(7'h24, 8'h19);
    u_host.rd(7'h34, 8'h00);
    u_host.rd(7'h28, 8'h00);
    u_host.wr(7'h14, 8'h40);
    u_host.rd(7'h14, 8'h40);
    count_ticks(64, 8);
    u_host.wr(7'h14, 8'h10);
    count_ticks(60, 20);
    u_host.wr(7'h14, 8'h50);
    count_ticks(32, 0);
    u_host.wr(7'h18, 8'h00);
    repeat (2) @(posedge clock);
    chk({7'h0, amp_out_a_oe | amp_out_b_oe}, 8'h00);
    for (int s = 0; s < 7; s++) begin
      u_host.wr(7'h24, 8'(s));
      repeat (3) @(posedge clock);
      chk({5'h0, mux_sel}, 8'(s));
      chk({7'h0, mic_boost_en}, {7'h0, s == 0});
    end
    // Immediate mode: level is the code times four eighths.
    u_host.wr(7'h24, 8'h01);
    g = $random(seed) % 25;
    u_host.wr(7'h20, {2'b00, 6'(g)});
    u_host.wr(7'h1C, {2'b00, 6'(-g)});
    repeat (4) @(posedge clock);
    chk(left_level, 8'(g * 4));
    chk(right_level, 8'(-g * 4));
    // Freeze holds a gain write until it is lifted.
    u_host.wr(7'h44, 8'h01);
    u_host.wr(7'h20, 8'h18);
    repeat (4) @(posedge clock);
    chk(left_level, 8'(g * 4));
    u_host.wr(7'h44, 8'h00);
    repeat (4) @(posedge clock);
    chk(left_level, 8'h60);
    // Zero cross mode waits for the crossing of its own channel.
    u_host.wr(7'h24, 8'h09);
    u_host.wr(7'h20, 8'h28);
    u_host.wr(7'h1C, 8'h08);
    repeat (4) @(posedge clock);
    chk(left_level, 8'h60);
    zero_cross <= 2'b01;
    @(posedge clock);
    zero_cross <= 2'b00;
    repeat (4) @(posedge clock);
    chk(left_level, 8'hA0);
    chk(right_level, 8'(-g * 4));
    // Right has seen no crossing: it waits out the timeout.
    repeat (3900) @(posedge clock);
    chk(right_level, 8'(-g * 4));
    repeat (300) @(posedge clock);
    chk(right_level, 8'h20);
    // Soft ramp, a clock-enable pause in mid ramp, then a soft mute.
    u_host.wr(7'h24, 8'h11);
    u_host.wr(7'h20, 8'h00);
    repeat (100) @(posedge clock);
    chk({6'h0, left_level == 8'h00, left_level == 8'hA0}, 8'h00);
    clk_en <= 1'b0;
    @(posedge clock);
    lvl = left_level;
    repeat (40) @(posedge clock);
    chk(left_level, lvl);
    clk_en <= 1'b1;
    repeat (800) @(posedge clock);
    chk(left_level, 8'h00);
    u_host.wr(7'h44, 8'h02);
    repeat (100) @(posedge clock);
    chk({6'h0, left_level == 8'h00, left_level == 8'h80}, 8'h00);
    // Status: rise, masked, fall, and the interrupt pin.
    u_host.wr(7'h38, 8'h0B);
    u_host.wr(7'h30, 8'h01);
    pulse_cond(1);
    chk({6'h0, irq_out, irq_oe}, 8'h03);
    u_host.rd(7'h34, 8'h02);
    u_host.rd(7'h34, 8'h00);
    repeat (3) @(posedge clock);
    chk({6'h0, irq_out, irq_oe}, 8'h01);
    pulse_cond(2);
    u_host.rd(7'h34, 8'h08);
    u_host.wr(7'h38, 8'h09);
    pulse_cond(1);
    u_host.rd(7'h34, 8'h00);
    u_host.wr(7'h30, 8'h00);
    u_host.wr(7'h40, 8'h01);
    @(posedge clock);
    under_range <= 1'b1;
    repeat (3) @(posedge clock);
    u_host.rd(7'h34, 8'h00);
    under_range <= 1'b0;
    repeat (3) @(posedge clock);
    chk({6'h0, irq_out, irq_oe}, 8'h01);
    u_host.wr(7'h38, 8'h08);
    u_host.rd(7'h34, 8'h00);
    u_host.wr(7'h40, 8'h00);
    u_host.wr(7'h3C, 8'h01);
    u_host.wr(7'h38, 8'h09);
    u_host.rd(7'h34, 8'h01);
    under_range <= 1'b1;
    repeat (3) @(posedge clock);
    u_host.rd(7'h34, 8'h01);
    u_host.rd(7'h34, 8'h01);
    under_range <= 1'b0;
    repeat (3) @(posedge clock);
    u_host.rd(7'h34, 8'h01);
    u_host.rd(7'h34, 8'h00);
    repeat (5) @(posedge clock);
    print_verdict();
  end
endmodule // adc_gain_input_status_regs_tb

// ==== sim/agisr_host.sv ====
// Purpose: Host model that reaches the register bank over Avalon-MM.
// Assumes: One request at a time, held until waitrequest is seen low.
// Notes:   Expected read bytes are queued for the bench monitor.
`timescale 1ns/1ps
module agisr_host (
  input wire logic clock,
  input wire logic avs_waitrequest,
  output logic [6:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  logic [7:0] exp_q[$];
  initial begin
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  // ==========================================================
  // Bus cycles
  task automatic xfer(input logic is_wr, input logic [6:0] a,
                      input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !is_wr;
    avs_write <= is_wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Gain codes handed here stay within the signed range of +-24 steps.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask
endmodule // agisr_host
